// file: ddr4_init_defines.vh
// Constants for the DDR4 reset, initialisation and access tracker
`ifndef DDR4_INIT_DEFINES_VH
`define DDR4_INIT_DEFINES_VH

// Clock rate and documented times
`define CLK_MHZ 25
`define INIT_TIME_US 500
`define XPR_MIN_NCK 4'h5
`define DLLK_NCK_DEF 1024
`define ZQINIT_NCK_DEF 1024

// Register byte addresses
`define REG_STATUS 8'h00
`define REG_CONTROL 8'h04
`define REG_MR_BASE 8'h08
`define REG_MR_LAST 8'h20
`define REG_ACT 8'h24
`define REG_ACCESS 8'h28
`define REG_BANKS 8'h2C

// AXI responses
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

// Init states
`define ST_RESET 3'h0
`define ST_INTERNAL 3'h1
`define ST_WAIT_CKE 3'h2
`define ST_MRS 3'h3
`define ST_CAL_WAIT 3'h4
`define ST_READY 3'h5

// Command codes on {ras_n, cas_n, we_n} when act_n is high
`define CMD_MRS 3'h0
`define CMD_REF 3'h1
`define CMD_PRE 3'h2
`define CMD_WR 3'h4
`define CMD_RD 3'h5
`define CMD_ZQ 3'h6

// Mode register select codes {bg0, ba1, ba0}
`define MR0 3'h0
`define MR1 3'h1
`define MR2 3'h2
`define MR3 3'h3
`define MR4 3'h4
`define MR5 3'h5
`define MR6 3'h6

// Address bit positions, burst length codes and beat counts
`define A_AP 10
`define A_BC 12
`define MR0_BL_LO 0
`define MR0_BL_HI 1
`define BL_FIXED8 2'h0
`define BL_OTF 2'h1
`define BL_FIXED4 2'h2
`define BEATS_8 4'h8
`define BEATS_4 4'h4
`define BEATS_PER_CK 4'h2

// Status bit positions
`define ST_ERR_ORDER 4
`define ST_ERR_XPR 5
`define ST_ERR_DES 6
`define ST_ERR_CKE 7
`define ST_ERR_CLOSED 8
`define ST_ERR_EARLY_ZQ 9
`define ERR_LO 4
`define ERR_HI 9

`endif

// file: sync2.v
// Two-flip-flop synchroniser for a group of pin inputs
module sync2 #(
  parameter WIDTH = 1
) (
  // Clock and reset
  input wire aclk,
  input wire aresetn,
  // Asynchronous in, synchronised out
  input wire [WIDTH-1:0] d,
  output reg [WIDTH-1:0] q
);
  reg [WIDTH-1:0] meta_q;

  // First stage feeds only the second
  always @(posedge aclk) begin
    if (!aresetn) begin
      meta_q <= {WIDTH{1'b0}};
      q <= {WIDTH{1'b0}};
    end else begin
      meta_q <= d;
      q <= meta_q;
    end
  end
endmodule

// file: ddr4_init_device.v
// DDR4 device-side reset, initialisation and access tracking with AXI4-Lite registers
//
// Local design decisions: the placing of the registers and the AXI4-Lite register port.
`include "ddr4_init_defines.vh"
module ddr4_init_device #(
  parameter INIT_CYCLES = `INIT_TIME_US * `CLK_MHZ,
  parameter DLLK_NCK = `DLLK_NCK_DEF,
  parameter ZQINIT_NCK = `ZQINIT_NCK_DEF
) (
  // Clock and reset
  input wire aclk,
  input wire aresetn,
  // AXI4-Lite write channels
  input wire [7:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  // AXI4-Lite read channels
  input wire [7:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  // Memory pins from the controller
  input wire ck,
  input wire reset_n,
  input wire cke,
  input wire cs_n,
  input wire act_n,
  input wire ras_n,
  input wire cas_n,
  input wire we_n,
  input wire bg0,
  input wire [1:0] ba,
  input wire [16:0] addr,
  input wire odt,
  input wire connectivity_test_enable,
  // Device state
  output reg term_enable_q,
  output reg init_done_q,
  output reg burst_active_q
);
  wire [29:0] pins_s;
  wire ck_s, rst_s, cke_s, cs_s, act_s, ras_s, cas_s, we_s, bg_s, odt_s, ten_s;
  wire [1:0] ba_s;
  wire [16:0] addr_s;
  reg ck_q;
  reg cke_prev_q;
  reg [2:0] state_q;
  reg [13:0] timer_q;
  reg [11:0] nck_q;
  reg [3:0] xpr_q;
  reg [2:0] mr_step_q;
  reg [16:0] mr_q [0:6];
  reg [7:0] bank_open_q;
  reg [14:0] row_q [0:7];
  reg [5:0] err_q;
  reg [1:0] ctrl_q;
  reg [2:0] act_bank_q;
  reg [14:0] act_row_q;
  reg [9:0] col_q;
  reg [2:0] acc_bank_q;
  reg ap_q, wr_q;
  reg [3:0] beats_q;
  reg [3:0] burst_len_q;
  reg aw_taken_q, w_taken_q;
  reg [7:0] awaddr_q;
  reg [31:0] wdata_q;
  reg [3:0] wstrb_q;
  reg [5:0] err_set;
  reg [2:0] expect_mr;
  reg [31:0] rd_val;
  reg rd_hit;
  wire ck_rise, cmd_en, is_des, is_act, is_mrs, is_zq, is_rd, is_wr, is_pre, do_write;
  wire [2:0] sel;
  wire [3:0] req_len;
  integer i;

  // Every pin is synchronised before use
  sync2 #(.WIDTH(30)) u_pins (
    .aclk(aclk),
    .aresetn(aresetn),
    .d({ck, reset_n, cke, cs_n, act_n, ras_n, cas_n, we_n, bg0, ba, addr, odt, connectivity_test_enable}),
    .q(pins_s)
  );
  assign {ck_s, rst_s, cke_s, cs_s, act_s, ras_s, cas_s, we_s, bg_s, ba_s, addr_s, odt_s, ten_s} = pins_s;

  // Command decode at each memory clock rising edge
  assign ck_rise = ck_s & ~ck_q;
  assign cmd_en = ck_rise & cke_s & cke_prev_q & ~ten_s;
  assign is_des = cs_s;
  assign sel = {bg_s, ba_s};
  assign is_act = cmd_en & ~cs_s & ~act_s;
  assign is_mrs = cmd_en & ~cs_s & act_s & ({ras_s, cas_s, we_s} == `CMD_MRS);
  assign is_pre = cmd_en & ~cs_s & act_s & ({ras_s, cas_s, we_s} == `CMD_PRE);
  assign is_wr = cmd_en & ~cs_s & act_s & ({ras_s, cas_s, we_s} == `CMD_WR);
  assign is_rd = cmd_en & ~cs_s & act_s & ({ras_s, cas_s, we_s} == `CMD_RD);
  assign is_zq = cmd_en & ~cs_s & act_s & ({ras_s, cas_s, we_s} == `CMD_ZQ) & addr_s[`A_AP];

  // Burst length from MR0 and the per-command chop bit
  assign req_len = (mr_q[`MR0][`MR0_BL_HI:`MR0_BL_LO] == `BL_FIXED4) ? `BEATS_4 :
    ((mr_q[`MR0][`MR0_BL_HI:`MR0_BL_LO] == `BL_OTF) && !addr_s[`A_BC]) ? `BEATS_4 : `BEATS_8;

  // Expected mode register for each step of the initial write order
  always @* begin
    case (mr_step_q)
      3'h0: expect_mr = `MR3;
      3'h1: expect_mr = `MR6;
      3'h2: expect_mr = `MR5;
      3'h3: expect_mr = `MR4;
      3'h4: expect_mr = `MR2;
      3'h5: expect_mr = `MR1;
      default: expect_mr = `MR0;
    endcase
  end

  // Error events raised by the sequence checks
  always @* begin
    err_set = 6'h00;
    if (state_q == `ST_WAIT_CKE && ck_rise && cke_s && !cke_prev_q && !is_des)
      err_set[`ST_ERR_DES-`ERR_LO] = 1'b1;
    if (is_mrs && state_q == `ST_MRS && sel != expect_mr)
      err_set[`ST_ERR_ORDER-`ERR_LO] = 1'b1;
    if (is_mrs && state_q == `ST_MRS && xpr_q < `XPR_MIN_NCK)
      err_set[`ST_ERR_XPR-`ERR_LO] = 1'b1;
    if ((state_q == `ST_MRS || state_q == `ST_CAL_WAIT) && ck_rise && !cke_s)
      err_set[`ST_ERR_CKE-`ERR_LO] = 1'b1;
    if ((is_rd || is_wr) && !bank_open_q[sel])
      err_set[`ST_ERR_CLOSED-`ERR_LO] = 1'b1;
    if (is_zq && state_q == `ST_MRS && mr_step_q != 3'h7)
      err_set[`ST_ERR_EARLY_ZQ-`ERR_LO] = 1'b1;
  end

  // Initialisation state machine; reset pin overrides without a memory clock edge
  always @(posedge aclk) begin
    if (!aresetn) begin
      state_q <= `ST_RESET;
      timer_q <= 14'h0000;
      nck_q <= 12'h000;
      xpr_q <= 4'h0;
      mr_step_q <= 3'h0;
      ck_q <= 1'b0;
      cke_prev_q <= 1'b0;
      init_done_q <= 1'b0;
      term_enable_q <= 1'b0;
    end else begin
      ck_q <= ck_s;
      if (ck_rise)
        cke_prev_q <= cke_s;
      if (!rst_s) begin
        state_q <= `ST_RESET;
        init_done_q <= 1'b0;
        term_enable_q <= 1'b0;
        cke_prev_q <= 1'b0;
      end else begin
        term_enable_q <= (state_q >= `ST_MRS) & odt_s;
        case (state_q)
          `ST_RESET: begin
            timer_q <= 14'h0000;
            state_q <= `ST_INTERNAL;
          end
          `ST_INTERNAL: begin
            // Counted on the system clock, independent of the memory clock
            if (timer_q >= INIT_CYCLES[13:0] - 14'h0001)
              state_q <= `ST_WAIT_CKE;
            else
              timer_q <= timer_q + 14'h0001;
          end
          `ST_WAIT_CKE: begin
            if (ck_rise && cke_s) begin
              state_q <= `ST_MRS;
              xpr_q <= 4'h1;
              mr_step_q <= 3'h0;
            end
          end
          `ST_MRS: begin
            if (ck_rise && xpr_q != 4'hF)
              xpr_q <= xpr_q + 4'h1;
            if (is_mrs && (!ctrl_q[0] || sel == expect_mr) && mr_step_q != 3'h7)
              mr_step_q <= mr_step_q + 3'h1;
            if (is_zq) begin
              state_q <= `ST_CAL_WAIT;
              nck_q <= 12'h000;
            end
          end
          `ST_CAL_WAIT: begin
            if (ck_rise) begin
              if (nck_q >= DLLK_NCK[11:0] - 12'h001 && nck_q >= ZQINIT_NCK[11:0] - 12'h001) begin
                state_q <= `ST_READY;
                init_done_q <= 1'b1;
              end else
                nck_q <= nck_q + 12'h001;
            end
          end
          `ST_READY: state_q <= `ST_READY;
          default: state_q <= `ST_RESET;
        endcase
      end
    end
  end

  // Mode registers, bank rows and burst tracking
  always @(posedge aclk) begin
    if (!aresetn || !rst_s) begin
      for (i = 0; i < 7; i = i + 1)
        mr_q[i] <= 17'h00000;
      for (i = 0; i < 8; i = i + 1)
        row_q[i] <= 15'h0000;
      bank_open_q <= 8'h00;
      act_bank_q <= 3'h0;
      act_row_q <= 15'h0000;
      col_q <= 10'h000;
      acc_bank_q <= 3'h0;
      ap_q <= 1'b0;
      wr_q <= 1'b0;
      beats_q <= 4'h0;
      burst_len_q <= 4'h0;
      burst_active_q <= 1'b0;
    end else begin
      if (is_mrs && sel <= `MR6 && (!ctrl_q[0] || state_q != `ST_MRS || sel == expect_mr))
        mr_q[sel] <= addr_s;
      if (is_act) begin
        bank_open_q[sel] <= 1'b1;
        row_q[sel] <= addr_s[14:0];
        act_bank_q <= sel;
        act_row_q <= addr_s[14:0];
      end
      if (is_pre)
        bank_open_q <= addr_s[`A_AP] ? 8'h00 : (bank_open_q & ~(8'h01 << sel));
      if ((is_rd || is_wr) && state_q == `ST_READY) begin
        col_q <= addr_s[9:0];
        acc_bank_q <= sel;
        ap_q <= addr_s[`A_AP];
        wr_q <= is_wr;
        burst_len_q <= req_len;
        beats_q <= req_len;
        burst_active_q <= 1'b1;
        if (addr_s[`A_AP])
          bank_open_q[sel] <= 1'b0;
      end else if (ck_rise && burst_active_q) begin
        // Two beats leave the pins per memory clock
        if (beats_q <= `BEATS_PER_CK) begin
          beats_q <= 4'h0;
          burst_active_q <= 1'b0;
        end else
          beats_q <= beats_q - `BEATS_PER_CK;
      end
    end
  end

  // AXI4-Lite write: address and data in either order, response after both
  assign s_axi_awready = ~aw_taken_q & ~s_axi_bvalid;
  assign s_axi_wready = ~w_taken_q & ~s_axi_bvalid;
  assign do_write = aw_taken_q & w_taken_q & ~s_axi_bvalid;
  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_taken_q <= 1'b0;
      w_taken_q <= 1'b0;
      awaddr_q <= 8'h00;
      wdata_q <= 32'h00000000;
      wstrb_q <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `RESP_OKAY;
      ctrl_q <= 2'h0;
      err_q <= 6'h00;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_taken_q <= 1'b1;
        awaddr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_taken_q <= 1'b1;
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
      end
      // Sticky errors: a new event wins over a write-one clear
      if (do_write && awaddr_q == `REG_STATUS && wstrb_q[1:0] != 2'h0)
        err_q <= (err_q & ~wdata_q[`ERR_HI:`ERR_LO]) | err_set;
      else
        err_q <= err_q | err_set;
      if (do_write) begin
        aw_taken_q <= 1'b0;
        w_taken_q <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (awaddr_q == `REG_STATUS || awaddr_q == `REG_CONTROL) ? `RESP_OKAY : `RESP_SLVERR;
        if (awaddr_q == `REG_CONTROL && wstrb_q[0])
          ctrl_q <= wdata_q[1:0];
      end else if (s_axi_bvalid && s_axi_bready)
        s_axi_bvalid <= 1'b0;
    end
  end

  // Read decode
  always @* begin
    rd_val = 32'h00000000;
    rd_hit = 1'b1;
    if (s_axi_araddr == `REG_STATUS)
      rd_val = {20'h00000, burst_active_q, ten_s, err_q, init_done_q, state_q};
    else if (s_axi_araddr == `REG_CONTROL)
      rd_val = {30'h00000000, ctrl_q};
    else if (s_axi_araddr >= `REG_MR_BASE && s_axi_araddr <= `REG_MR_LAST && s_axi_araddr[1:0] == 2'h0)
      rd_val = {15'h0000, mr_q[s_axi_araddr[4:2] - 3'h2]};
    else if (s_axi_araddr == `REG_ACT)
      rd_val = {14'h0000, act_bank_q, act_row_q};
    else if (s_axi_araddr == `REG_ACCESS)
      rd_val = {9'h000, burst_len_q, beats_q, wr_q, ap_q, acc_bank_q, col_q};
    else if (s_axi_araddr == `REG_BANKS)
      rd_val = {24'h000000, bank_open_q};
    else
      rd_hit = 1'b0;
  end

  // AXI4-Lite read channel
  assign s_axi_arready = ~s_axi_rvalid;
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= `RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_val;
      s_axi_rresp <= rd_hit ? `RESP_OKAY : `RESP_SLVERR;
    end else if (s_axi_rvalid && s_axi_rready)
      s_axi_rvalid <= 1'b0;
  end
endmodule

// file: ddr4_init_checker_asserts.sv
// Concurrent checks on the DDR4 device initialisation block ports
module ddr4_init_checker #(
  parameter INIT_CYCLES = 20
) (
  // Clock and reset
  input wire aclk,
  input wire aresetn,
  // Bus handshakes
  input wire s_axi_arvalid,
  input wire s_axi_arready,
  input wire s_axi_rvalid,
  input wire s_axi_rready,
  input wire [31:0] s_axi_rdata,
  input wire s_axi_bvalid,
  input wire s_axi_bready,
  input wire [1:0] s_axi_bresp,
  // Memory pins and state
  input wire ck,
  input wire reset_n,
  input wire cke,
  input wire term_enable_q,
  input wire init_done_q,
  input wire burst_active_q
);
  logic ck_q;
  logic [2:0] rise_q;
  logic [15:0] wait_q;
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // Clock rises inside a burst and cycles since the reset pin let go
  always @(posedge aclk) begin
    ck_q <= ck;
    rise_q <= !burst_active_q ? 3'h0 : rise_q + {2'h0, ck & !ck_q};
    wait_q <= !reset_n ? 16'h0 : wait_q + {15'h0, wait_q != 16'hFFFF};
  end
  term_in_reset_a: assert property (!reset_n [*4] |-> !term_enable_q)
    else $error("termination active in reset");
  term_needs_cke_a: assert property ($rose(term_enable_q) |-> cke && reset_n)
    else $error("termination on before clock enable");
  done_cleared_a: assert property (!reset_n [*4] |-> !init_done_q && !burst_active_q)
    else $error("state kept through reset");
  init_wait_a: assert property ($rose(init_done_q) |-> wait_q > INIT_CYCLES)
    else $error("ready before internal init time");
  done_needs_cke_a: assert property ($rose(init_done_q) |-> cke)
    else $error("ready without clock enable");
  burst_len_a: assert property (burst_active_q |-> rise_q <= 3'h4)
    else $error("burst longer than four clocks");
  burst_end_a: assert property ($rose(burst_active_q) |-> ##[1:40] !burst_active_q)
    else $error("burst never ends");
  bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  read_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read not answered next cycle");
endmodule
bind ddr4_init_device ddr4_init_checker #(.INIT_CYCLES(INIT_CYCLES)) i_chk (
  .aclk(aclk), .aresetn(aresetn),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_bresp(s_axi_bresp),
  .ck(ck), .reset_n(reset_n), .cke(cke),
  .term_enable_q(term_enable_q), .init_done_q(init_done_q), .burst_active_q(burst_active_q)
);

// file: ddr4_ctl_model.sv
// Memory controller model driving reset, clock, clock enable and commands
module ddr4_ctl_model #(
  parameter RESET_WAIT = 24
) (
  // Bench clock
  input wire aclk,
  // Memory pins
  output logic ck,
  output logic reset_n,
  output logic cke,
  output logic cs_n,
  output logic act_n,
  output logic ras_n,
  output logic cas_n,
  output logic we_n,
  output logic bg0,
  output logic [1:0] ba,
  output logic [16:0] addr,
  output logic odt,
  output logic connectivity_test_enable
);
  timeunit 1ns;
  timeprecision 1ns;
  logic run = 1'b0;
  // Pin levels from power-up: reset and test enable low, deselected
  initial begin
    {reset_n, cke, odt, connectivity_test_enable} = 4'h0;
    {cs_n, act_n, ras_n, cas_n, we_n} = 5'h1F;
    {bg0, ba, addr} = 20'h0;
  end
  // Link clock, still while stopped, out of phase with aclk
  initial begin
    ck = 1'b0;
    #13;
    forever #160 ck = run ? ~ck : 1'b0;
  end
  // One command set up after a fall and taken at the next rise
  task automatic rise(input [24:0] c);
    @(negedge ck);
    @(posedge aclk);
    {cs_n, act_n, ras_n, cas_n, we_n, bg0, ba, addr} <= c;
    @(posedge ck);
  endtask
  // Deselects; released lines show the inverse of their last level
  task automatic des(input int n);
    repeat (n) rise({1'b1, ~{act_n, ras_n, cas_n, we_n, bg0, ba, addr}});
  endtask
  // Whole reset and init; a bad run breaks the deselect, wait and order
  task automatic init(input bit bad);
    bit [20:0] seq;
    bit [2:0] sel;
    seq = bad ? 21'o6354210 : 21'o3654210;
    @(posedge aclk);
    run <= 1'b0;
    cke <= 1'b0;
    reset_n <= 1'b0;
    repeat (16) @(posedge aclk);
    reset_n <= 1'b1;
    repeat (RESET_WAIT) @(posedge aclk);
    run <= 1'b1;
    repeat (6) @(posedge ck);
    @(negedge ck);
    @(posedge aclk);
    cke <= 1'b1;
    cs_n <= !bad;
    {act_n, ras_n, cas_n, we_n} <= 4'hF;
    @(posedge ck);
    if (!bad)
      des(5);
    for (int i = 0; i < 7; i++) begin
      sel = seq[20 - 3 * i -: 3];
      rise({5'b01000, sel, 5'h00, sel, 9'h000});
      des(1);
    end
    rise({5'b01110, 3'h0, 17'h00400});
  endtask
  // Termination and test-enable levels, changed just after a bench clock edge
  task automatic pins(input bit term, input bit test);
    @(posedge aclk);
    odt <= term;
    connectivity_test_enable <= test;
  endtask
endmodule

// file: ddr4_init_device_bench.sv
// Self-checking bench for the DDR4 device initialisation block
module ddr4_init_device_bench;
  timeunit 1ns;
  timeprecision 1ns;
  logic aclk, aresetn, ck, reset_n, cke, cs_n, act_n, ras_n, cas_n, we_n, bg0, odt;
  logic connectivity_test_enable, term_enable_q, init_done_q, burst_active_q;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [1:0] ba, s_axi_bresp, s_axi_rresp;
  logic [3:0] s_axi_wstrb;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [16:0] addr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rdat;
  int failures = 0;
  int check_count = 0;
  ddr4_init_device #(.INIT_CYCLES(20), .DLLK_NCK(8), .ZQINIT_NCK(8)) i_dut (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .ck(ck), .reset_n(reset_n), .cke(cke), .cs_n(cs_n), .act_n(act_n), .ras_n(ras_n),
    .cas_n(cas_n), .we_n(we_n), .bg0(bg0), .ba(ba), .addr(addr), .odt(odt),
    .connectivity_test_enable(connectivity_test_enable),
    .term_enable_q(term_enable_q), .init_done_q(init_done_q), .burst_active_q(burst_active_q)
  );
  ddr4_ctl_model i_ctl (
    .aclk(aclk), .ck(ck), .reset_n(reset_n), .cke(cke), .cs_n(cs_n), .act_n(act_n),
    .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n), .bg0(bg0), .ba(ba), .addr(addr), .odt(odt),
    .connectivity_test_enable(connectivity_test_enable)
  );
  // Bench clock
  initial begin
    aclk = 1'b0;
    forever #20 aclk = ~aclk;
  end
  // Compare and count
  task automatic chk(input [31:0] seen, input [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      failures++;
      $display("FAIL at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // Bus write, address and data offered together
  task automatic wr(input [7:0] a, input [31:0] d, input [3:0] s, input [1:0] er);
    logic ta, tw, tb;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= s;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
    do begin
      @(negedge aclk);
      ta = s_axi_awvalid & s_axi_awready;
      tw = s_axi_wvalid & s_axi_wready;
      tb = s_axi_bvalid;
      rdat = {30'h0, s_axi_bresp};
      @(posedge aclk);
      if (ta)
        s_axi_awvalid <= 1'b0;
      if (tw)
        s_axi_wvalid <= 1'b0;
    end while (!tb);
    s_axi_bready <= 1'b0;
    chk(rdat, {30'h0, er});
  endtask
  // Bus read, masked compare of data and response
  task automatic rd(input [7:0] a, input [31:0] m, input [31:0] exp, input [1:0] er);
    logic ta, tr;
    logic [1:0] rsp;
    @(posedge aclk);
    s_axi_araddr <= a;
    {s_axi_arvalid, s_axi_rready} <= 2'h3;
    do begin
      @(negedge aclk);
      ta = s_axi_arvalid & s_axi_arready;
      tr = s_axi_rvalid;
      rdat = s_axi_rdata;
      rsp = s_axi_rresp;
      @(posedge aclk);
      if (ta)
        s_axi_arvalid <= 1'b0;
    end while (!tr);
    s_axi_rready <= 1'b0;
    chk(rdat & m, exp);
    chk({30'h0, rsp}, {30'h0, er});
  endtask
  // Register defaults, control access and refused places
  task automatic t_regs;
    rd(8'h00, 32'hFFF, 32'h0, 2'h0);
    @(negedge aclk);
    chk(term_enable_q, 1'b0);
    wr(8'h04, 32'h1, 4'hF, 2'h0);
    rd(8'h04, 32'h3, 32'h1, 2'h0);
    wr(8'h04, 32'h0, 4'hF, 2'h0);
    rd(8'h30, 32'hFFFFFFFF, 32'h0, 2'h2);
    wr(8'h08, 32'h5, 4'hF, 2'h2);
    rd(8'h08, 32'h1FFFF, 32'h0, 2'h0);
  endtask
  // Faulty start in strict order mode: no deselect, no exit wait, wrong order; then clear
  task automatic t_bad;
    wr(8'h04, 32'h1, 4'hF, 2'h0);
    i_ctl.init(1'b1);
    i_ctl.des(12);
    rd(8'h00, 32'h70, 32'h70, 2'h0);
    rd(8'h00, 32'h200, 32'h200, 2'h0);
    rd(8'h14, 32'h1FFFF, 32'h600, 2'h0);
    rd(8'h20, 32'h1FFFF, 32'h0, 2'h0);
    wr(8'h00, 32'h3F0, 4'h0, 2'h0);
    rd(8'h00, 32'h3F0, 32'h270, 2'h0);
    wr(8'h00, 32'h3F0, 4'hF, 2'h0);
    rd(8'h00, 32'h3F0, 32'h0, 2'h0);
  endtask
  // Clean start after a reset with power held
  task automatic t_good;
    i_ctl.init(1'b0);
    i_ctl.des(4);
    chk(init_done_q, 1'b0);
    i_ctl.des(8);
    chk(init_done_q, 1'b1);
    rd(8'h00, 32'hFFF, 32'h00D, 2'h0);
    for (int i = 0; i < 7; i++)
      rd(8'h08 + 8'(4 * i), 32'h1FFFF, 32'(i) << 9, 2'h0);
    i_ctl.pins(1'b1, 1'b0);
    repeat (4) @(posedge aclk);
    @(negedge aclk);
    chk(term_enable_q, 1'b1);
    i_ctl.pins(1'b0, 1'b0);
  endtask
  // Activate, read with auto precharge, then a read to the closed bank
  task automatic t_burst;
    i_ctl.rise({5'b00110, 3'h5, 17'h01234});
    i_ctl.des(1);
    rd(8'h24, 32'h3FFFF, 32'h29234, 2'h0);
    rd(8'h2C, 32'hFF, 32'h20, 2'h0);
    i_ctl.rise({5'b01101, 3'h5, 17'h007C8});
    repeat (4) @(posedge aclk);
    @(negedge aclk);
    chk(burst_active_q, 1'b1);
    i_ctl.des(5);
    chk(burst_active_q, 1'b0);
    rd(8'h28, 32'h7FFFFF, 32'h4037C8, 2'h0);
    rd(8'h2C, 32'hFF, 32'h0, 2'h0);
    i_ctl.rise({5'b01101, 3'h5, 17'h003C8});
    i_ctl.des(5);
    rd(8'h00, 32'h100, 32'h100, 2'h0);
    // Test enable high: an activate is ignored and the status shows the pin
    i_ctl.pins(1'b0, 1'b1);
    i_ctl.rise({5'b00110, 3'h2, 17'h00055});
    i_ctl.des(1);
    rd(8'h2C, 32'hFF, 32'h0, 2'h0);
    rd(8'h00, 32'h400, 32'h400, 2'h0);
    i_ctl.pins(1'b0, 1'b0);
  endtask
  // Verdict and end of run
  task automatic complete_run;
    $display("Checks %0d, failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  // Watchdog
  initial begin
    repeat (40000) @(posedge aclk);
    failures++;
    complete_run;
  end
  // Main sequence
  initial begin
    aresetn = 1'b0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = 52'h0;
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    t_regs;
    t_bad;
    t_good;
    t_burst;
    complete_run;
  end
endmodule
